// ---- hdl/rx_hs_pkg.sv ----
// Purpose: shared constants and types of the serial receive handshake block
// Assumes: one clock domain, synchronous active-low reset
// Notes:   register offsets are byte addresses on the plain register port
package rx_hs_pkg;

    // ==========================================================
    // image and buffer sizes
    localparam int IN_BYTES = 22;
    localparam int FIFO_DEPTH = 128;
    localparam int IDX_W = 5;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_LEVEL = 8'h08;
    localparam logic [7:0] ADDR_HANDSHAKE = 8'h0c;

    // ==========================================================
    // event bit positions, shared by status and mask
    localparam int NUM_EVENTS = 5;
    localparam int EV_OVERFLOW = 0;
    localparam int EV_PARITY = 1;
    localparam int EV_FRAMING = 2;
    localparam int EV_OVERRUN = 3;
    localparam int EV_FULL = 4;

    // handshake register fields
    localparam int HS_TX_ACK = 0;
    localparam int HS_RX_REQ = 1;
    localparam int HS_INIT_DONE = 2;
    localparam int HS_COUNT_LSB = 8;

    // reset values
    localparam logic [NUM_EVENTS-1:0] STATUS_RESET = 5'h00;
    localparam logic [NUM_EVENTS-1:0] MASK_RESET = 5'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // ==========================================================
    // types
    typedef logic [7:0] byte_t;
    typedef byte_t [IN_BYTES-1:0] byte_block_t;

    typedef struct packed {
        logic valid;
        logic parity_err;
        logic framing_err;
        logic overrun_err;
        byte_t data;
    } rx_char_t;

    typedef struct packed {
        logic tx_ack_toggle;
        logic rx_req_toggle;
        logic init_done;
        logic rx_fifo_full;
        logic parity_fault;
        logic framing_fault;
        logic overrun_fault;
    } in_flags_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FILL = 2'b01,
        ST_INIT = 2'b10
    } deliver_state_t;

endpackage

// ---- hdl/sticky_flags.sv ----
// Purpose: sticky event flags, write-one-to-clear
// Assumes: set and clear are single-cycle terms of the same clock
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps
module sticky_flags #(
    parameter int N = 5
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // events and clears
    input wire logic [N-1:0] set_in,
    input wire logic [N-1:0] clr_in,
    // flags
    output logic [N-1:0] flags_out
);
    logic [N-1:0] flags_d;

    // ==========================================================
    // next value per flag, one register process keeps a single driver
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_flag
            assign flags_d[g] = set_in[g] | (flags_out[g] & ~clr_in[g]);
        end
    endgenerate

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            flags_out <= '0;
        end else begin
            flags_out <= flags_d;
        end
    end
endmodule

// ---- hdl/char_fifo.sv ----
// Purpose: receive character FIFO in flip-flops
// Assumes: push is only offered while push_ready_out is high
// Notes:   flush empties it in one cycle and wins over push and pop
`timescale 1ns/1ps
module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic flush_in,
    // fill side
    input wire logic push_valid_in,
    input wire logic [WIDTH-1:0] push_data_in,
    output logic push_ready_out,
    // drain side
    input wire logic pop_ready_in,
    output logic pop_valid_out,
    output logic [WIDTH-1:0] pop_data_out,
    output logic [15:0] level_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    wire do_push = push_valid_in & push_ready_out;
    wire do_pop = pop_ready_in & pop_valid_out;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == LAST) ? '0 : p + AW'(1);
    endfunction

    assign push_ready_out = (cnt_q != FULL_CNT);
    assign pop_valid_out = (cnt_q != '0);
    assign pop_data_out = mem_q[rd_q];
    assign level_out = 16'(cnt_q);

    // ==========================================================
    // storage and pointers
    always_ff @(posedge core_clk_in) begin
        if (do_push) begin
            mem_q[wr_q] <= push_data_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in || flush_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) wr_q <= next_ptr(wr_q);
            if (do_pop) rd_q <= next_ptr(rd_q);
            cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
        end
    end
endmodule

// ---- hdl/serial_rx_handshake_status.sv ----
// Purpose: receive-side image, toggle handshakes and diagnostics
// Assumes: serial framing checks are done upstream, one character a cycle
// Notes:   the image is filled from the FIFO in bursts of up to 22 bytes
`timescale 1ns/1ps
module serial_rx_handshake_status #(
    parameter int FIFO_DEPTH = rx_hs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic irq_out,
    // serial receive path
    input wire rx_hs_pkg::rx_char_t rx_char_in,
    // controller outputs
    input wire logic tx_req_toggle_in,
    input wire logic [7:0] out_len_in,
    input wire rx_hs_pkg::byte_block_t outbound_byte_array_in,
    input wire logic controller_rx_ack_toggle_in,
    input wire logic init_req_in,
    // transmit path
    input wire logic tx_path_ready_in,
    output logic tx_block_valid_out,
    output logic [7:0] tx_len_out,
    output rx_hs_pkg::byte_block_t tx_block_out,
    // controller input image
    output rx_hs_pkg::byte_block_t inbound_byte_array_out,
    output logic [7:0] in_byte_count_out,
    output rx_hs_pkg::in_flags_t in_flags_out
);
    import rx_hs_pkg::*;

    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(IN_BYTES - 1);
    localparam logic [7:0] MAX_COUNT = 8'(IN_BYTES);

    // ==========================================================
    // state
    deliver_state_t state_q;
    deliver_state_t state_d;
    logic [IDX_W-1:0] idx_q;
    logic [IDX_W-1:0] idx_d;
    logic tx_ack_q;
    logic rx_req_q;
    logic init_done_q;
    logic fifo_full_q;
    logic [NUM_EVENTS-1:0] mask_q;
    logic [NUM_EVENTS-1:0] status;
    logic [NUM_EVENTS-1:0] ev_set;
    logic [NUM_EVENTS-1:0] ev_clr;
    logic [31:0] rd_mux;
    logic [15:0] fifo_level;
    logic fifo_ready;
    logic fifo_valid;
    byte_t fifo_data;

    // ==========================================================
    // receive path checks
    wire init_active = (state_q == ST_INIT);
    wire rx_live = rx_char_in.valid & ~init_active;
    wire rx_bad = rx_char_in.parity_err | rx_char_in.framing_err |
                  rx_char_in.overrun_err;
    wire rx_good = rx_live & ~rx_bad;
    // bad characters never reach the FIFO
    wire fifo_push = rx_good & fifo_ready;
    wire fifo_pop = (state_q == ST_FILL) & fifo_valid;

    // ==========================================================
    // handshake terms
    wire rx_idle = (rx_req_q == controller_rx_ack_toggle_in);
    // a new block is only offered once the last one was acknowledged
    wire tx_pending = (tx_req_toggle_in != tx_ack_q);
    wire tx_take = tx_pending & tx_path_ready_in & ~init_active;
    wire fill_last = fifo_pop & (idx_q == LAST_IDX);
    wire fill_end = fill_last | ~fifo_valid;
    wire [7:0] fill_count = fifo_pop ? 8'(idx_q) + 8'h01 : 8'(idx_q);

    // ==========================================================
    // register decode
    wire wr_status = reg_wr_in & (reg_addr_in == ADDR_STATUS);
    wire wr_mask = reg_wr_in & (reg_addr_in == ADDR_MASK);

    assign ev_set[EV_OVERFLOW] = rx_good & ~fifo_ready;
    assign ev_set[EV_PARITY] = rx_live & rx_char_in.parity_err;
    assign ev_set[EV_FRAMING] = rx_live & rx_char_in.framing_err;
    assign ev_set[EV_OVERRUN] = rx_live & rx_char_in.overrun_err;
    assign ev_set[EV_FULL] = ~fifo_ready & ~init_active;
    assign ev_clr = wr_status ? reg_wdata_in[NUM_EVENTS-1:0] : '0;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_addr_in)
            ADDR_STATUS: rd_mux[NUM_EVENTS-1:0] = status;
            ADDR_MASK: rd_mux[NUM_EVENTS-1:0] = mask_q;
            ADDR_LEVEL: rd_mux[15:0] = fifo_level;
            ADDR_HANDSHAKE: begin
                rd_mux[HS_TX_ACK] = tx_ack_q;
                rd_mux[HS_RX_REQ] = rx_req_q;
                rd_mux[HS_INIT_DONE] = init_done_q;
                rd_mux[HS_COUNT_LSB +: 8] = in_byte_count_out;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // delivery state machine
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        case (state_q)
            ST_IDLE: begin
                if (init_req_in) begin
                    state_d = ST_INIT;
                end else if (rx_idle && fifo_valid) begin
                    state_d = ST_FILL;
                    idx_d = '0;
                end
            end
            ST_FILL: begin
                if (init_req_in) begin
                    state_d = ST_INIT;
                end else if (fill_end) begin
                    state_d = ST_IDLE;
                end else begin
                    idx_d = idx_q + IDX_W'(1);
                end
            end
            // held until the controller drops its request
            ST_INIT: begin
                if (!init_req_in) state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            idx_q <= '0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
        end
    end

    // ==========================================================
    // input image
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            inbound_byte_array_out <= '0;
            in_byte_count_out <= COUNT_RESET;
            rx_req_q <= 1'b0;
        end else begin
            // only written in a fill, which starts only when acknowledged
            if (fifo_pop && !init_req_in) begin
                inbound_byte_array_out[idx_q] <= fifo_data;
            end
            // bytes land first, length and toggle with the 22nd byte, or a cycle after the last byte when the FIFO runs dry
            if (state_q == ST_FILL && fill_end && !init_req_in) begin
                in_byte_count_out <= fill_count;
                rx_req_q <= ~rx_req_q;
            end
        end
    end

    // ==========================================================
    // outbound acceptance
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            tx_ack_q <= 1'b0;
            tx_block_valid_out <= 1'b0;
            tx_len_out <= 8'h00;
            tx_block_out <= '0;
        end else begin
            tx_block_valid_out <= tx_take;
            if (tx_take) begin
                tx_ack_q <= ~tx_ack_q;
                tx_len_out <= out_len_in;
                tx_block_out <= outbound_byte_array_in;
            end
        end
    end

    // ==========================================================
    // init, flags, interrupt and read data
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            init_done_q <= 1'b0;
            fifo_full_q <= 1'b0;
            mask_q <= MASK_RESET;
            irq_out <= 1'b0;
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            init_done_q <= init_active;
            fifo_full_q <= ~fifo_ready;
            if (wr_mask) mask_q <= reg_wdata_in[NUM_EVENTS-1:0];
            irq_out <= |(status & mask_q);
            reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
        end
    end

    always_comb begin
        in_flags_out = '0;
        in_flags_out.tx_ack_toggle = tx_ack_q;
        in_flags_out.rx_req_toggle = rx_req_q;
        in_flags_out.init_done = init_done_q;
        in_flags_out.rx_fifo_full = fifo_full_q;
        in_flags_out.parity_fault = status[EV_PARITY];
        in_flags_out.framing_fault = status[EV_FRAMING];
        in_flags_out.overrun_fault = status[EV_OVERRUN];
    end

    // ==========================================================
    // submodules
    sticky_flags #(
        .N(NUM_EVENTS)
    ) u_flags (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .set_in(ev_set),
        .clr_in(ev_clr),
        .flags_out(status)
    );

    // flush clears pointers while init is pending
    char_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .flush_in(init_active),
        .push_valid_in(fifo_push),
        .push_data_in(rx_char_in.data),
        .push_ready_out(fifo_ready),
        .pop_ready_in(fifo_pop),
        .pop_valid_out(fifo_valid),
        .pop_data_out(fifo_data),
        .level_out(fifo_level)
    );

    // ==========================================================
    // checks
    overflow_flag_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rx_good && !fifo_ready) |=> status[EV_OVERFLOW])
        else $error("overflow not flagged");

    parity_drop_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rx_live && rx_char_in.parity_err) |-> !fifo_push
            ##1 status[EV_PARITY])
        else $error("parity character kept or not flagged");

    framing_drop_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rx_live && rx_char_in.framing_err) |-> !fifo_push
            ##1 status[EV_FRAMING])
        else $error("framing character kept or not flagged");

    overrun_drop_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rx_live && rx_char_in.overrun_err) |-> !fifo_push
            ##1 status[EV_OVERRUN])
        else $error("overrun character kept or not flagged");

    full_discard_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (fifo_level == 16'(FIFO_DEPTH) && !init_active) |-> !fifo_push
            ##1 (status[EV_FULL] && in_flags_out.rx_fifo_full))
        else $error("full FIFO not flagged or still written");

    tx_ack_flip_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        tx_take |=> (tx_ack_q != $past(tx_ack_q)) && tx_block_valid_out
            && (tx_ack_q == $past(tx_req_toggle_in)))
        else $error("transmit acknowledge did not invert");

    rx_req_len_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (rx_req_q != $past(rx_req_q)) |-> (in_byte_count_out != 8'h00)
            && (in_byte_count_out <= MAX_COUNT))
        else $error("request toggled with bad length");

    image_hold_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (!rx_idle && state_q != ST_FILL) |=>
            $stable(inbound_byte_array_out) && $stable(in_byte_count_out))
        else $error("image changed before controller accept");

    init_done_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        init_active |=> init_done_q && fifo_level == 16'h0000)
        else $error("init not acknowledged or FIFO not flushed");

    init_release_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (init_active && !init_req_in) |=> ##1 !init_done_q)
        else $error("init done stuck after release");

    tx_take_only_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        !tx_take |=> !tx_block_valid_out && $stable(tx_ack_q))
        else $error("transmit acknowledge moved without a take");

    rx_req_end_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        !(state_q == ST_FILL && fill_end) |=> $stable(rx_req_q))
        else $error("receive request toggled outside a fill end");

    init_block_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        init_active |=> !tx_block_valid_out && $stable(rx_req_q))
        else $error("transfer went on during init");

    idx_range_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (state_q == ST_FILL) |-> (idx_q <= LAST_IDX))
        else $error("fill index beyond the last byte position");

endmodule

// ---- test/ctrl_model.sv ----
// Purpose: controller partner that copies inbound blocks and sends outbound
// Assumes: one clock, synchronous active-low reset
// Notes:   hold_in stalls the receive acknowledge to build back-pressure
`timescale 1ns/1ps
module ctrl_model (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // commands from the bench
    input wire logic hold_in,
    input wire logic send_in,
    input wire logic [7:0] send_len_in,
    // device image
    input wire rx_hs_pkg::in_flags_t flags_in,
    input wire rx_hs_pkg::byte_block_t image_in,
    input wire logic [7:0] count_in,
    // controller outputs
    output logic rx_ack_toggle_out,
    output logic tx_req_toggle_out,
    output logic [7:0] out_len_out,
    output rx_hs_pkg::byte_block_t out_bytes_out,
    // last copied block, for the bench
    output rx_hs_pkg::byte_block_t copy_out,
    output logic [7:0] copy_len_out
);
    import rx_hs_pkg::*;

    logic pending_q;
    wire logic rx_new = flags_in.rx_req_toggle != rx_ack_toggle_out;
    // a new block only once the last one was acknowledged
    wire logic can_send = send_in && !pending_q &&
        (flags_in.tx_ack_toggle == tx_req_toggle_out);

    // ==========================================================
    // handshakes
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            rx_ack_toggle_out <= 1'b0;
            tx_req_toggle_out <= 1'b0;
            pending_q <= 1'b0;
            out_len_out <= 8'h00;
            out_bytes_out <= '0;
            copy_out <= '0;
            copy_len_out <= 8'h00;
        end else begin
            if (!hold_in && rx_new) begin
                copy_out <= image_in;
                copy_len_out <= count_in;
                rx_ack_toggle_out <= ~rx_ack_toggle_out;
            end
            // bytes settle a cycle before the toggle
            if (pending_q) begin
                tx_req_toggle_out <= ~tx_req_toggle_out;
                pending_q <= 1'b0;
            end else if (can_send) begin
                out_len_out <= send_len_in;
                for (int i = 0; i < IN_BYTES; i++) begin
                    out_bytes_out[i] <= send_len_in + 8'(i);
                end
                pending_q <= 1'b1;
            end
        end
    end
endmodule

// ---- test/serial_rx_handshake_status_tb.sv ----
// Purpose: self-checking bench of the receive handshake block
// Assumes: FIFO shrunk to 32 so that full and overflow come quickly
// Notes:   a partner model plays the controller side
`timescale 1ns/1ps
module serial_rx_handshake_status_tb;
    import rx_hs_pkg::*;

    typedef struct {
        logic [2:0] err;
        logic [31:0] status;
        logic toggles;
    } row_t;

    logic core_clk, rst_n, reg_wr, reg_rd, irq, tx_req, rx_ack, init_req;
    logic tx_ready, tx_valid, hold, send;
    logic [7:0] reg_addr, out_len, tx_len, in_count, send_len, copy_len;
    logic [31:0] reg_wdata, reg_rdata, d;
    rx_char_t rx_char;
    byte_block_t out_bytes, tx_block, image, copy;
    in_flags_t flags;
    int errors, check_count, takes;
    logic [7:0] addrs[5] = '{ADDR_STATUS, ADDR_MASK, ADDR_LEVEL,
        ADDR_HANDSHAKE, 8'h10};
    row_t rows[4] = '{'{3'b100, 32'h02, 1'b0}, '{3'b010, 32'h04, 1'b0},
        '{3'b001, 32'h08, 1'b0}, '{3'b000, 32'h00, 1'b1}};

    serial_rx_handshake_status #(.FIFO_DEPTH(32)) i_dut (
        .core_clk_in(core_clk), .rst_n_in(rst_n),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .irq_out(irq), .rx_char_in(rx_char),
        .tx_req_toggle_in(tx_req), .out_len_in(out_len),
        .outbound_byte_array_in(out_bytes),
        .controller_rx_ack_toggle_in(rx_ack), .init_req_in(init_req),
        .tx_path_ready_in(tx_ready), .tx_block_valid_out(tx_valid),
        .tx_len_out(tx_len), .tx_block_out(tx_block),
        .inbound_byte_array_out(image), .in_byte_count_out(in_count),
        .in_flags_out(flags));

    ctrl_model i_ctrl (
        .core_clk_in(core_clk), .rst_n_in(rst_n), .hold_in(hold),
        .send_in(send), .send_len_in(send_len), .flags_in(flags),
        .image_in(image), .count_in(in_count), .rx_ack_toggle_out(rx_ack),
        .tx_req_toggle_out(tx_req), .out_len_out(out_len),
        .out_bytes_out(out_bytes), .copy_out(copy),
        .copy_len_out(copy_len));

    // ==========================================================
    // clock, watchdog, take counter
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        #(8 * 5000);
        errors++;
        wrap_up();
    end

    always @(posedge core_clk) begin
        if (tx_valid === 1'b1) begin
            takes++;
        end
    end

    // ==========================================================
    // tasks
    task automatic check(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // data stand only in the cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        v = reg_rdata;
    endtask

    task automatic chars(input logic [2:0] err, input logic [7:0] v, int n);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            rx_char <= {1'b1, err, v + 8'(i)};
        end
        @(posedge core_clk);
        rx_char <= '0;
    endtask

    task automatic wait_copy(input logic [7:0] n, first);
        logic a;
        a = rx_ack;
        for (int i = 0; i < 200 && rx_ack === a; i++) begin
            @(posedge core_clk);
        end
        #1;
        check("copy ack", 32'(!a), 32'(rx_ack));
        check("copy length", 32'(n), 32'(copy_len));
        check("copy first", 32'(first), 32'(copy[0]));
        check("copy last", 32'(first + n - 8'h01), 32'(copy[n - 1]));
    endtask

    task automatic send_block(input logic [7:0] n);
        @(posedge core_clk);
        send <= 1'b1;
        send_len <= n;
        @(posedge core_clk);
        send <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic r;
        logic a;
        rst_n = 1'b0;
        {reg_wr, reg_rd, init_req, hold, send, tx_ready} = 6'b000001;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        send_len = 8'h00;
        rx_char = '0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rows[k]) begin
            r = flags.rx_req_toggle ^ rows[k].toggles;
            chars(rows[k].err, 8'h41, 1);
            repeat (8) @(posedge core_clk);
            rd(ADDR_STATUS, d);
            check("status", rows[k].status, d);
            check("flag copy", 32'(rows[k].err), 32'(flags[2:0]));
            check("req", 32'(r), 32'(flags.rx_req_toggle));
            wr(ADDR_STATUS, 32'h1f);
        end
        $display("done: character rows");
        // first block stays unacknowledged while the FIFO overflows
        hold <= 1'b1;
        chars(3'b000, 8'ha0, 1);
        repeat (8) @(posedge core_clk);
        chars(3'b000, 8'h00, 33);
        rd(ADDR_LEVEL, d);
        check("level", 32'd32, d);
        check("full", 32'h1, 32'(flags.rx_fifo_full));
        rd(ADDR_STATUS, d);
        check("overflow", 32'h11, d);
        check("held count", 32'h1, 32'(in_count));
        check("held byte", 32'ha0, 32'(image[0]));
        rd(ADDR_HANDSHAKE, d);
        check("handshake", 32'h100, d);
        check("irq masked", 32'h0, 32'(irq));
        wr(ADDR_MASK, 32'h10);
        repeat (2) @(posedge core_clk);
        check("irq", 32'h1, 32'(irq));
        hold <= 1'b0;
        wait_copy(8'd1, 8'ha0);
        wait_copy(8'd22, 8'h00);
        wait_copy(8'd10, 8'h16);
        wr(ADDR_STATUS, 32'h1f);
        repeat (2) @(posedge core_clk);
        check("irq clear", 32'h0, 32'(irq));
        $display("done: overflow and delivery");
        // take waits for the transmit path, then back to back
        tx_ready <= 1'b0;
        a = flags.tx_ack_toggle;
        send_block(8'd5);
        repeat (10) @(posedge core_clk);
        check("no take", 32'h0, 32'(takes));
        tx_ready <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("take", 32'h1, 32'(takes));
        check("ack", 32'(!a), 32'(flags.tx_ack_toggle));
        check("tx len", 32'd5, 32'(tx_len));
        check("tx byte", 32'd9, 32'(tx_block[4]));
        send_block(8'd22);
        repeat (6) @(posedge core_clk);
        check("take 2", 32'h2, 32'(takes));
        check("ack 2", 32'(a), 32'(flags.tx_ack_toggle));
        check("tx last", 32'd43, 32'(tx_block[21]));
        $display("done: transmit handshake");
        // init flushes held characters and ignores new ones
        hold <= 1'b1;
        chars(3'b000, 8'h30, 1);
        repeat (8) @(posedge core_clk);
        chars(3'b000, 8'h31, 3);
        init_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("init done", 32'h1, 32'(flags.init_done));
        chars(3'b100, 8'h55, 1);
        rd(ADDR_LEVEL, d);
        check("flushed", 32'h0, d);
        rd(ADDR_STATUS, d);
        check("no flag in init", 32'h0, d);
        @(posedge core_clk);
        init_req <= 1'b0;
        repeat (4) @(posedge core_clk);
        check("init ready", 32'h0, 32'(flags.init_done));
        hold <= 1'b0;
        $display("done: init");
        // mid-run reset, then reset values and refused places
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        wr(ADDR_HANDSHAKE, 32'hffff_ffff);
        wr(8'h10, 32'hffff_ffff);
        foreach (addrs[k]) begin
            rd(addrs[k], d);
            check("reset read", 32'h0, d);
        end
        wr(ADDR_MASK, 32'h1f);
        rd(ADDR_MASK, d);
        check("mask", 32'h1f, d);
        $display("done: reset and registers");
        wrap_up();
    end
endmodule
